// [hdl/pbs_basic_status.sv]
/*
  Basic status register of a 10/100 transceiver with its serial
  management interface slave: frame decode, preamble suppression,
  read-out of the status word and the latched flags.
  Assumes the management pins and status inputs are synchronous to
  i_ref_clk, and that the data pin wire is resolved outside from
  o_mdio and o_mdio_oe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"

module pbs_basic_status
  import pbs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_an_complete,
  input wire logic i_far_end_fault,
  input wire logic i_partner_fault,
  input wire logic i_link_up,
  input wire logic i_jabber,
  output logic o_mdio,
  output logic o_mdio_oe
);

  pbs_smi_type r_q;
  pbs_smi_type r_d;
  logic rise;
  logic bit_in;
  logic [`PBS_NUM_FLAGS-1:0] flag_evt;
  logic [`PBS_NUM_FLAGS-1:0] flag_q;
  logic link_rd;
  logic [15:0] status_word;

  function automatic logic op_valid(input logic [1:0] op);
    op_valid = (op == `PBS_OP_READ) || (op == `PBS_OP_WRITE);
  endfunction

  pbs_mdc_sampler u_samp (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_mdc(i_mdc),
    .i_mdio(i_mdio),
    .o_rise(rise),
    .o_bit(bit_in)
  );

  assign flag_evt[`PBS_FLAG_RF] = i_far_end_fault | i_partner_fault;
  assign flag_evt[`PBS_FLAG_LOST] = ~i_link_up;
  // Jabber only arises in 10 Mb/s operation, so it carries no meaning at 100
  assign flag_evt[`PBS_FLAG_JAB] = i_jabber;

  genvar g;
  generate
    for (g = 0; g < `PBS_NUM_FLAGS; g = g + 1) begin : g_flag
      pbs_latch_flag u_flag (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_event(flag_evt[g]),
        .i_rd_clr(r_q.rd_clr),
        .o_flag(flag_q[g])
      );
    end
  endgenerate

  // Latched-low link: zero until a read after the loss, then live
  assign link_rd = i_link_up & ~flag_q[`PBS_FLAG_LOST];

  always_comb begin
    status_word = `PBS_FIXED_BITS;
    status_word[`PBS_BIT_AN_DONE] = i_an_complete;
    status_word[`PBS_BIT_REMOTE_FAULT] = flag_q[`PBS_FLAG_RF];
    status_word[`PBS_BIT_LINK] = link_rd;
    status_word[`PBS_BIT_JABBER] = flag_q[`PBS_FLAG_JAB];
  end

  always_comb begin
    r_d = r_q;
    r_d.rd_clr = 1'b0;
    if (rise) begin
      case (r_q.st)
        ST_IDLE: begin
          if (bit_in) begin
            if (r_q.ones != `PBS_PREAMBLE_LEN) begin
              r_d.ones = r_q.ones + 6'h01;
            end
          end else begin
            // Start bit accepted bare unless a full preamble is owed
            if (!r_q.need_pre || r_q.ones == `PBS_PREAMBLE_LEN) begin
              r_d.st = ST_START;
            end
            r_d.ones = 6'h00;
          end
        end
        ST_START: begin
          r_d.cnt = 5'h00;
          r_d.st = bit_in ? ST_HDR : ST_IDLE;
        end
        ST_HDR: begin
          r_d.sh = {r_q.sh[10:0], bit_in};
          r_d.cnt = r_q.cnt + 5'h01;
          if (r_q.cnt[3:0] == `PBS_HDR_LAST) begin
            r_d.cnt = 5'h00;
            if (!op_valid(r_q.sh[10:9])) begin
              r_d.need_pre = 1'b1;
              r_d.st = ST_IDLE;
            end else begin
              r_d.match = (r_q.sh[8:4] == r_q.phy_addr);
              r_d.is_status = ({r_q.sh[3:0], bit_in} == `PBS_REG_BASIC_STATUS);
              r_d.st = (r_q.sh[10:9] == `PBS_OP_READ) ? ST_TA_RD : ST_TA_WR;
            end
          end
        end
        ST_TA_RD: begin
          // The master's first turnaround bit cannot be checked: it floats
          r_d.need_pre = 1'b0;
          r_d.cnt = 5'h00;
          r_d.st = ST_RD_DATA;
          if (r_q.match) begin
            r_d.mdio_o = 1'b0;
            r_d.mdio_oe = 1'b1;
            r_d.dout = r_q.is_status ? status_word : 16'h0000;
            r_d.rd_clr = r_q.is_status;
          end
        end
        ST_RD_DATA: begin
          r_d.cnt = r_q.cnt + 5'h01;
          r_d.mdio_o = r_q.dout[15];
          r_d.dout = {r_q.dout[14:0], 1'b0};
          if (r_q.cnt == `PBS_DATA_BITS) begin
            r_d.mdio_o = 1'b0;
            r_d.mdio_oe = 1'b0;
            r_d.st = ST_IDLE;
          end
        end
        ST_TA_WR: begin
          r_d.sh = {r_q.sh[10:0], bit_in};
          r_d.cnt = r_q.cnt + 5'h01;
          if (r_q.cnt[0]) begin
            r_d.cnt = 5'h00;
            if ({r_q.sh[0], bit_in} == `PBS_TA_WRITE) begin
              r_d.need_pre = 1'b0;
              r_d.st = ST_WR_DATA;
            end else begin
              r_d.need_pre = 1'b1;
              r_d.st = ST_IDLE;
            end
          end
        end
        ST_WR_DATA: begin
          // Data is consumed but stored nowhere: no flag is touched
          r_d.cnt = r_q.cnt + 5'h01;
          if (r_q.cnt == `PBS_DATA_BITS - 5'h01) begin
            r_d.st = ST_IDLE;
          end
        end
        default: begin
          r_d.st = ST_IDLE;
          r_d.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.need_pre <= 1'b1;
      // Address strap caught while reset is held
      r_q.phy_addr <= i_phy_addr;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_mdio = r_q.mdio_o;
  assign o_mdio_oe = r_q.mdio_oe;

endmodule

`default_nettype wire

// [hdl/pbs_cfg.svh]
/*
  Constants for the basic status register block: frame field values,
  bit positions of the status word, fixed bits and counts.
  Assumes it is included by bare name by every file that needs it.
*/
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_REG_BASIC_STATUS 5'h01
`define PBS_FIXED_BITS 16'h7849
`define PBS_BIT_AN_DONE 5
`define PBS_BIT_REMOTE_FAULT 4
`define PBS_BIT_LINK 2
`define PBS_BIT_JABBER 1
`define PBS_PREAMBLE_LEN 6'h20
`define PBS_OP_READ 2'h2
`define PBS_OP_WRITE 2'h1
`define PBS_TA_WRITE 2'h2
`define PBS_HDR_LAST 4'hb
`define PBS_DATA_BITS 5'h10
`define PBS_NUM_FLAGS 3
`define PBS_FLAG_RF 0
`define PBS_FLAG_LOST 1
`define PBS_FLAG_JAB 2

`endif

// [hdl/pbs_latch_flag.sv]
/*
  One sticky flag: set by an event, cleared by a register read.
  Assumes i_rd_clr is a one-cycle pulse from the read logic.
*/
`timescale 1ns/10ps
`default_nettype none

module pbs_latch_flag
  import pbs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_event,
  input wire logic i_rd_clr,
  output logic o_flag
);

  pbs_flag_type f_q;
  pbs_flag_type f_d;

  always_comb begin
    f_d = f_q;
    // Event wins over a clear in the same cycle
    f_d.flag = i_event | (f_q.flag & ~i_rd_clr);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign o_flag = f_q.flag;

endmodule

`default_nettype wire

// [hdl/pbs_mdc_sampler.sv]
/*
  Samples the management clock and data pins on the system clock and
  marks each rising edge of the management clock.
  Assumes both pins are already synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pbs_mdc_sampler
  import pbs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_rise,
  output logic o_bit
);

  pbs_samp_type s_q;
  pbs_samp_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.mdc = i_mdc;
    s_d.mdc_prev = s_q.mdc;
    s_d.mdio = i_mdio;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Data taken with the clock level, so both belong to the same edge
  assign o_rise = s_q.mdc & ~s_q.mdc_prev;
  assign o_bit = s_q.mdio;

endmodule

`default_nettype wire

// [hdl/pbs_pkg.sv]
/*
  Types shared by the basic status register block.
  Assumes pbs_cfg.svh is on the include path.
*/
`include "pbs_cfg.svh"

package pbs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_TA_RD,
    ST_RD_DATA,
    ST_TA_WR,
    ST_WR_DATA
  } pbs_state_type;

  typedef struct packed {
    pbs_state_type st;
    logic [5:0] ones;
    logic need_pre;
    logic [4:0] cnt;
    logic [11:0] sh;
    logic [15:0] dout;
    logic mdio_o;
    logic mdio_oe;
    logic rd_clr;
    logic [4:0] phy_addr;
    logic match;
    logic is_status;
  } pbs_smi_type;

  typedef struct packed {
    logic mdc;
    logic mdc_prev;
    logic mdio;
  } pbs_samp_type;

  typedef struct packed {
    logic flag;
  } pbs_flag_type;

endpackage

// [verification/pbs_checker.sv]
/*
  Checker for the basic status block: decodes read replies at the pins.
  Assumes status inputs stay still while a frame is on the wire.
*/
`timescale 1ns/10ps
`default_nettype none
module pbs_checker (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  input wire logic i_an_complete,
  input wire logic i_far_end_fault,
  input wire logic i_partner_fault,
  input wire logic i_link_up,
  input wire logic i_jabber,
  input wire logic o_mdio,
  input wire logic o_mdio_oe
);
  logic mdc_q, oe_q, reg1, rf, jb, lost;
  logic [5:0] hd;
  logic [15:0] w;
  logic [3:0] ex;
  logic [4:0] rc;
  wire rise = i_mdc & ~mdc_q;
  wire snap = o_mdio_oe & ~oe_q & (hd[5:1] == 5'h01);
  wire flt = i_far_end_fault | i_partner_fault;
  // Shadow latches; inputs are still during frames, so snapshot skew is harmless
  always_ff @(posedge i_ref_clk) begin
    mdc_q <= i_mdc;
    oe_q <= o_mdio_oe;
    if (rise && !o_mdio_oe) hd <= {hd[4:0], i_mdio};
    if (rise && o_mdio_oe) w <= {w[14:0], o_mdio};
    if (o_mdio_oe && !oe_q) reg1 <= hd[5:1] == 5'h01;
    rc <= (o_mdio_oe && !oe_q) ? 5'h00 : rc + 5'(rise && o_mdio_oe);
    rf <= flt | (rf & ~snap);
    jb <= i_jabber | (jb & ~snap);
    lost <= ~i_link_up | (lost & ~(snap & i_link_up));
    if (snap) ex <= {i_an_complete, rf | flt, i_link_up & ~lost, jb | i_jabber};
    if (i_srst) {reg1, rf, jb, lost} <= '0;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_end; $fell(o_mdio_oe) && reg1; endsequence
  property p_b15; s_end |-> w[15] == 1'b0; endproperty
  property p_cap; s_end |-> w[14:11] == 4'hf; endproperty
  property p_pre; s_end |-> w[6]; endproperty
  property p_an; s_end |-> w[5] == ex[3]; endproperty
  property p_rf; s_end |-> w[4] == ex[2]; endproperty
  property p_ab; s_end |-> w[3]; endproperty
  property p_lk; s_end |-> w[2] == ex[1]; endproperty
  property p_jb; s_end |-> w[1] == ex[0]; endproperty
  property p_ext; s_end |-> w[0] && w[10:7] == 4'h0; endproperty
  property p_len; $fell(o_mdio_oe) |-> rc == 5'h11; endproperty
  a_b15: assert property (p_b15) else $error("bit 15 set");
  a_cap: assert property (p_cap) else $error("speed bits wrong");
  a_pre: assert property (p_pre) else $error("bit 6 clear");
  a_an: assert property (p_an) else $error("bit 5 wrong");
  a_rf: assert property (p_rf) else $error("bit 4 wrong");
  a_ab: assert property (p_ab) else $error("bit 3 clear");
  a_lk: assert property (p_lk) else $error("bit 2 wrong");
  a_jb: assert property (p_jb) else $error("bit 1 wrong");
  a_ext: assert property (p_ext) else $error("bit 0 or reserved");
  a_len: assert property (p_len) else $error("reply length");
  c_read: cover property (s_end);
  c_fault: cover property (snap && rf);
  c_lost: cover property (snap && lost);
endmodule
bind pbs_basic_status pbs_checker u_pbs_checker (
  .i_ref_clk(i_ref_clk),
  .i_srst(i_srst),
  .i_mdc(i_mdc),
  .i_mdio(i_mdio),
  .i_an_complete(i_an_complete),
  .i_far_end_fault(i_far_end_fault),
  .i_partner_fault(i_partner_fault),
  .i_link_up(i_link_up),
  .i_jabber(i_jabber),
  .o_mdio(o_mdio),
  .o_mdio_oe(o_mdio_oe)
);
`default_nettype wire

// [verification/pbs_smi_master.sv]
/*
  Management master model: sends frames and collects read data.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module pbs_smi_master (
  input wire logic i_ref_clk,
  input wire logic i_wire,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_oe
);
  // Turnaround sent by writes; the bench sets a bad code to test refusal
  logic [1:0] ta_code = 2'b10;
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_oe = 1'b0;
  end
  // Clock rests low between frames; in read frames the wire floats from the turnaround on
  task automatic xfer(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, output logic [15:0] rd);
    logic [31:0] f;
    f = {2'b01, op, pa, ra, ta_code, 16'h0000};
    for (int i = -32; i < 32; i++) begin
      if (i >= 0 || pre) begin
        @(posedge i_ref_clk);
        o_mdc <= 1'b0;
        o_oe <= !(op == 2'h2 && i >= 14);
        o_mdio <= (i < 0) ? 1'b1 : f[31 - i];
        repeat (4) @(posedge i_ref_clk);
        if (i >= 16) rd = {rd[14:0], i_wire};
        o_mdc <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
      end
    end
    @(posedge i_ref_clk);
    o_mdc <= 1'b0;
    o_oe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
/*
  Bench for the basic status block: table of flag reads, then refusals,
  a write and a reset in mid-run. Assumes the master model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [4:0] i_phy_addr = 5'h05;
  logic i_an_complete = 0, i_far_end_fault = 0, i_partner_fault = 0, i_link_up = 1;
  logic i_jabber = 0;
  logic i_mdc, i_mdio, o_mdio, o_mdio_oe, m_mdio, m_oe;
  logic [15:0] got;
  int mismatches = 0, n_tests = 0, cyc = 0;
  logic [5:0] ctl [13] = '{6'h05, 6'h25, 6'h15, 6'h05, 6'h0d, 6'h07, 6'h05,
    6'h01, 6'h05, 6'h00, 6'h00, 6'h05, 6'h05};
  logic [15:0] exp_w [13] = '{16'h784d, 16'h786d, 16'h785d, 16'h784d,
    16'h785d, 16'h784f, 16'h784d, 16'h7849, 16'h784d, 16'h7849, 16'h7849, 16'h7849,
    16'h784d};
  // Pull-up on the data wire
  assign i_mdio = o_mdio_oe ? o_mdio : (m_oe ? m_mdio : 1'b1);
  pbs_basic_status u_pbs_basic_status (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_mdc(i_mdc),
    .i_mdio(i_mdio),
    .i_phy_addr(i_phy_addr),
    .i_an_complete(i_an_complete),
    .i_far_end_fault(i_far_end_fault),
    .i_partner_fault(i_partner_fault),
    .i_link_up(i_link_up),
    .i_jabber(i_jabber),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe)
  );
  pbs_smi_master u_pbs_smi_master (.i_ref_clk(i_ref_clk), .i_wire(i_mdio),
    .o_mdc(i_mdc), .o_mdio(m_mdio), .o_oe(m_oe));
  always #5 i_ref_clk = ~i_ref_clk;
  task automatic stop_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic go(input logic p, input logic [1:0] op, input logic [4:0] pa,
                    input logic [4:0] ra, input logic [15:0] e);
    u_pbs_smi_master.xfer(p, op, pa, ra, got);
    n_tests += (op == 2'h2);
    if (op == 2'h2 && got !== e) begin
      mismatches++;
      $display("BAD read_word exp %h got %h", e, got);
    end
  endtask
  // Event phase, then faults and jabber drop and the link settles
  task automatic ev(input logic [5:0] c);
    @(posedge i_ref_clk);
    {i_an_complete, i_far_end_fault, i_partner_fault, i_link_up, i_jabber} <= c[5:1];
    repeat (4) @(posedge i_ref_clk);
    {i_far_end_fault, i_partner_fault, i_link_up, i_jabber} <= {2'b00, c[0], 1'b0};
    repeat (4) @(posedge i_ref_clk);
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      ev(ctl[i]);
      go(i == 0, 2'h2, 5'h05, 5'h01, exp_w[i]);
    end
    ev(6'h15);
    go(0, 2'h1, 5'h05, 5'h01, 16'h0000);
    go(0, 2'h2, 5'h06, 5'h01, 16'hffff);
    go(0, 2'h2, 5'h05, 5'h00, 16'h0000);
    go(0, 2'h2, 5'h05, 5'h01, 16'h785d);
    go(0, 2'h0, 5'h05, 5'h01, 16'h0000);
    go(0, 2'h2, 5'h05, 5'h01, 16'hffff);
    go(1, 2'h2, 5'h05, 5'h01, 16'h784d);
    ev(6'h07);
    i_srst <= 1'b1;
    i_phy_addr <= 5'h0a;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    go(0, 2'h2, 5'h0a, 5'h01, 16'hffff);
    go(1, 2'h2, 5'h0a, 5'h01, 16'h784d);
    // Write with a bad turnaround must leave a preamble owed
    u_pbs_smi_master.ta_code = 2'b01;
    go(0, 2'h1, 5'h0a, 5'h01, 16'h0000);
    u_pbs_smi_master.ta_code = 2'b10;
    go(0, 2'h2, 5'h0a, 5'h01, 16'hffff);
    go(1, 2'h2, 5'h0a, 5'h01, 16'h784d);
    stop_test();
  end
endmodule
`default_nettype wire
